// ### logic/laor_params.svh
// register offsets, reset values and limits for alarm routing
`ifndef LAOR_PARAMS_SVH
`define LAOR_PARAMS_SVH
`define LAOR_OFF_CTRL 12'h000
`define LAOR_OFF_SEL 12'h004
`define LAOR_OFF_HYST 12'h008
`define LAOR_OFF_LBTIME 12'h00c
`define LAOR_OFF_LBLEVEL 12'h010
`define LAOR_OFF_LBBAND 12'h014
`define LAOR_OFF_STATUS 12'h018
`define LAOR_OFF_INPUTS 12'h01c
`define LAOR_CTRL_RST 32'h0000_0000
`define LAOR_SEL_RST 15'h0c01
`define LAOR_HYST_MIN 16'h0001
`define LAOR_HYST_MAX 16'h01f4
`define LAOR_TIME_MAX 16'h270f
`define LAOR_LVL_T_RST 16'h0050
`define LAOR_LVL_A_RST 16'h03e8
`define LAOR_BND_T_RST 16'h001e
`define LAOR_BND_A_RST 16'h0014
`define LAOR_LVL_T_MIN 16'h0001
`define LAOR_LVL_T_MAX 16'h270f
`define LAOR_LVL_A_MIN 16'h0001
`define LAOR_LVL_A_MAX 16'h270f
`define LAOR_BND_MAX 16'h270f
`define LAOR_ALM_TYPE_LB 4'hc
`define LAOR_TICKS_PER_SEC 16'h0004
`define LAOR_SRC_WB0 5'h08
`define LAOR_SRC_WB7 5'h0f
`endif

// ### logic/laor_pkg.sv
// types for loop alarm and output routing
package laor_pkg;
  typedef enum logic [4:0] {
    LAOR_SRC_NONE = 5'h00, LAOR_SRC_HEAT = 5'h01, LAOR_SRC_COOL = 5'h02,
    LAOR_SRC_ALARM_ONE_SOURCE = 5'h03, LAOR_SRC_ALM2 = 5'h04, LAOR_SRC_ALM3 = 5'h05,
    LAOR_SRC_PEND = 5'h06, LAOR_SRC_SWCNT = 5'h07
  } laor_src_t;
  typedef struct packed {
    logic heat;
    logic cool;
    logic alm2;
    logic alm3;
    logic prog_end;
    logic switch_count_alarm_source;
    logic [7:0] work_bits;
  } laor_sig_t;
  typedef enum logic [1:0] {
    LAOR_LB_IDLE = 2'b00, LAOR_LB_WATCH = 2'b01, LAOR_LB_TRIP = 2'b10
  } laor_lb_t;
endpackage

// ### logic/laor_core.sv
// alarm hysteresis, loop burnout detection and output routing with apb
//
// Function
// - heater-short hysteresis is accepted from 0.1 to 50.0 A, default 0.1, and releases that alarm.
// - hysteresis applies only with heater-short enabled, alarm 1 assigned and latch off.
// - detection interval runs 0 to 9999 s, default 0, and 0 disables burnout detection.
// - burnout detection is active only with alarm 1 assigned and alarm type 12.
// - a burnout is flagged when deviation exceeds the level, ranges and defaults by input kind.
// - past the level, a deviation above the band that is not reduced flags a burnout.
// - level and band are unavailable while the interval is zero.
// - control output 1 takes one of sixteen sources, default heating.
// - cooling routed under standard control drives the 0 percent value.
// - on output 1 alarm, end, count and work bit sources need relay or ssr hardware.
// - program end may be chosen with the pattern off but then stays inactive.
// - work bit sources are hidden when the logic operation function is unused.
// - a current-type output 1 is assignable only while transfer output is off.
// - output 2 defaults to none and follows cooling under heating/cooling control.
// - output 2 offers the same sources as output 1.
// - auxiliary output 1 offers the same sources and defaults to alarm 1.
//
// Chosen here: register access over APB and the register addresses.
`include "laor_params.svh"
module laor_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic sample_tick,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire laor_pkg::laor_sig_t sigs,
  input wire logic [15:0] heater_short_current,
  input wire logic [15:0] heater_short_limit,
  input wire logic [15:0] deviation,
  output logic ctrl_out1_ff,
  output logic ctrl_out2_ff,
  output logic aux_out1_ff,
  output logic alarm_one_source_ff,
  output logic loop_burnout_alarm_ff
);
  import laor_pkg::*;

  // ctrl: 0 hs_use 1 alarm_one_source_assigned 2 hs_latch 3 heat_cool 4 analog 5 pattern
  // 6 logic_op 7 out1_relay 8 out1_current 9 xfer_off 11:10 unused 15:12 type
  logic [31:0] ctrl_ff;
  logic [14:0] sel_ff;
  logic [15:0] hyst_ff, lbtime_ff, lblevel_ff, lbband_ff;
  logic lb_valid;
  logic analog_prev_ff;
  laor_lb_t lb_state_ff;
  logic [15:0] tick_cnt_ff, sec_cnt_ff, dev_ref_ff;
  logic hs_alarm_ff;

  wire hs_use = ctrl_ff[0];
  wire alarm_one_source_asg = ctrl_ff[1];
  wire hs_latch = ctrl_ff[2];
  wire heat_cool = ctrl_ff[3];
  wire analog = ctrl_ff[4];
  wire pattern_on = ctrl_ff[5];
  wire logic_op = ctrl_ff[6];
  wire out1_relay = ctrl_ff[7];
  wire out1_current = ctrl_ff[8];
  wire xfer_off = ctrl_ff[9];
  wire [3:0] alarm_one_source_type = ctrl_ff[15:12];

  wire acc = psel & penable & clk_en;
  wire wr = acc & pwrite;

  function automatic logic [15:0] clip(input logic [15:0] v,
                                       input logic [15:0] lo,
                                       input logic [15:0] hi);
    clip = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // hidden or illegal choices leave the stored selection unchanged
  function automatic logic src_ok(input logic [4:0] s, input logic is_out1);
    logic ok;
    ok = 1'b1;
    if (s >= `LAOR_SRC_WB0 && !logic_op)
      ok = 1'b0;
    if (is_out1 && s >= LAOR_SRC_ALARM_ONE_SOURCE && !out1_relay)
      ok = 1'b0;
    if (is_out1 && out1_current && !xfer_off)
      ok = 1'b0;
    if (s > `LAOR_SRC_WB7)
      ok = 1'b0;
    src_ok = ok;
  endfunction

  function automatic logic route(input logic [4:0] s);
    logic r;
    r = 1'b0;
    unique case (s)
      LAOR_SRC_NONE: r = 1'b0;
      LAOR_SRC_HEAT: r = sigs.heat;
      LAOR_SRC_COOL: r = heat_cool & sigs.cool;
      LAOR_SRC_ALARM_ONE_SOURCE: r = alarm_one_source_ff;
      LAOR_SRC_ALM2: r = sigs.alm2;
      LAOR_SRC_ALM3: r = sigs.alm3;
      LAOR_SRC_PEND: r = pattern_on & sigs.prog_end;
      LAOR_SRC_SWCNT: r = sigs.switch_count_alarm_source;
      default: r = logic_op & sigs.work_bits[s[2:0]];
    endcase
    route = r;
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= `LAOR_CTRL_RST;
    end else if (wr && paddr == `LAOR_OFF_CTRL) begin
      ctrl_ff <= pwdata;
    end
  end

  // selectors: [4:0] out1 [9:5] out2 [14:10] aux1
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_ff <= `LAOR_SEL_RST;
    end else if (clk_en) begin
      if (wr && paddr == `LAOR_OFF_SEL) begin
        if (src_ok(pwdata[4:0], 1'b1))
          sel_ff[4:0] <= pwdata[4:0];
        if (src_ok(pwdata[9:5], 1'b0))
          sel_ff[9:5] <= pwdata[9:5];
        if (src_ok(pwdata[14:10], 1'b0))
          sel_ff[14:10] <= pwdata[14:10];
      end else if (heat_cool) begin
        sel_ff[9:5] <= LAOR_SRC_COOL;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hyst_ff <= `LAOR_HYST_MIN;
    end else if (wr && paddr == `LAOR_OFF_HYST) begin
      hyst_ff <= clip(pwdata[15:0], `LAOR_HYST_MIN, `LAOR_HYST_MAX);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lbtime_ff <= 16'h0000;
    end else if (wr && paddr == `LAOR_OFF_LBTIME) begin
      lbtime_ff <= clip(pwdata[15:0], 16'h0000, `LAOR_TIME_MAX);
    end
  end

  // level and band defaults follow the input kind when it changes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lblevel_ff <= `LAOR_LVL_T_RST;
      lbband_ff <= `LAOR_BND_T_RST;
      analog_prev_ff <= 1'b0;
    end else if (clk_en) begin
      analog_prev_ff <= analog;
      if (analog != analog_prev_ff) begin
        lblevel_ff <= analog ? `LAOR_LVL_A_RST : `LAOR_LVL_T_RST;
        lbband_ff <= analog ? `LAOR_BND_A_RST : `LAOR_BND_T_RST;
      end else if (wr && lb_valid && paddr == `LAOR_OFF_LBLEVEL) begin
        lblevel_ff <= clip(pwdata[15:0], `LAOR_LVL_T_MIN,
                           `LAOR_LVL_T_MAX);
      end else if (wr && lb_valid && paddr == `LAOR_OFF_LBBAND) begin
        lbband_ff <= clip(pwdata[15:0], 16'h0000, `LAOR_BND_MAX);
      end
    end
  end

  assign lb_valid = (lbtime_ff != 16'h0000);
  wire lb_active = lb_valid && alarm_one_source_asg && alarm_one_source_type == `LAOR_ALM_TYPE_LB;

  // watch starts when the level is passed; each interval the deviation must
  // fall by more than the band or the burnout trips
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lb_state_ff <= LAOR_LB_IDLE;
      tick_cnt_ff <= 16'h0000;
      sec_cnt_ff <= 16'h0000;
      dev_ref_ff <= 16'h0000;
    end else if (clk_en && sample_tick) begin
      if (!lb_active) begin
        lb_state_ff <= LAOR_LB_IDLE;
      end else begin
        unique case (lb_state_ff)
          LAOR_LB_IDLE: if (deviation > lblevel_ff) begin
            lb_state_ff <= LAOR_LB_WATCH;
            dev_ref_ff <= deviation;
            tick_cnt_ff <= 16'h0000;
            sec_cnt_ff <= 16'h0000;
          end
          LAOR_LB_WATCH: begin
            if (tick_cnt_ff == `LAOR_TICKS_PER_SEC - 16'h0001) begin
              tick_cnt_ff <= 16'h0000;
              if (sec_cnt_ff == lbtime_ff - 16'h0001) begin
                sec_cnt_ff <= 16'h0000;
                if (deviation + lbband_ff >= dev_ref_ff &&
                    deviation > lbband_ff)
                  lb_state_ff <= LAOR_LB_TRIP;
                else if (deviation <= lblevel_ff)
                  lb_state_ff <= LAOR_LB_IDLE;
                dev_ref_ff <= deviation;
              end else begin
                sec_cnt_ff <= sec_cnt_ff + 16'h0001;
              end
            end else begin
              tick_cnt_ff <= tick_cnt_ff + 16'h0001;
            end
          end
          LAOR_LB_TRIP: if (deviation <= lbband_ff)
            lb_state_ff <= LAOR_LB_IDLE;
          default: lb_state_ff <= LAOR_LB_IDLE;
        endcase
      end
    end
  end

  // heater-short alarm sets at the limit and clears below limit - hyst
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hs_alarm_ff <= 1'b0;
    end else if (clk_en && sample_tick) begin
      if (!(hs_use && alarm_one_source_asg))
        hs_alarm_ff <= 1'b0;
      else if (heater_short_current >= heater_short_limit)
        hs_alarm_ff <= 1'b1;
      else if (!hs_latch &&
               ({1'b0, heater_short_current} + {1'b0, hyst_ff}) <
               {1'b0, heater_short_limit})
        hs_alarm_ff <= 1'b0;
    end
  end

  // routed outputs only move on the tick, so a selector write cannot glitch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm_one_source_ff <= 1'b0;
      loop_burnout_alarm_ff <= 1'b0;
      ctrl_out1_ff <= 1'b0;
      ctrl_out2_ff <= 1'b0;
      aux_out1_ff <= 1'b0;
    end else if (clk_en && sample_tick) begin
      loop_burnout_alarm_ff <= lb_state_ff == LAOR_LB_TRIP;
      alarm_one_source_ff <= hs_alarm_ff | (lb_state_ff == LAOR_LB_TRIP);
      ctrl_out1_ff <= route(sel_ff[4:0]);
      ctrl_out2_ff <= route(sel_ff[9:5]);
      aux_out1_ff <= route(sel_ff[14:10]);
    end
  end

  // zero-wait slave; unmapped addresses answer with pslverr
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready <= psel & ~penable;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (psel && !penable) begin
        unique case (paddr)
          `LAOR_OFF_CTRL: prdata <= ctrl_ff;
          `LAOR_OFF_SEL: prdata <= {17'h00000, sel_ff};
          `LAOR_OFF_HYST: prdata <= {16'h0000, hyst_ff};
          `LAOR_OFF_LBTIME: prdata <= {16'h0000, lbtime_ff};
          `LAOR_OFF_LBLEVEL: prdata <= {16'h0000, lblevel_ff};
          `LAOR_OFF_LBBAND: prdata <= {16'h0000, lbband_ff};
          `LAOR_OFF_STATUS: prdata <= {27'h0000000, aux_out1_ff,
            ctrl_out2_ff, ctrl_out1_ff, loop_burnout_alarm_ff, hs_alarm_ff};
          `LAOR_OFF_INPUTS: prdata <= {16'h0000, deviation};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  AST_HYST_RANGE: assert property (@(posedge pclk) disable iff (!presetn)
    hyst_ff >= `LAOR_HYST_MIN && hyst_ff <= `LAOR_HYST_MAX)
    else $error("hysteresis out of range");
  AST_HS_LATCH: assert property (@(posedge pclk) disable iff (!presetn)
    hs_latch && hs_use && alarm_one_source_asg && $past(hs_latch) && $past(hs_use)
    && $past(alarm_one_source_asg) && $past(hs_alarm_ff) |-> hs_alarm_ff)
    else $error("latched alarm released");
  AST_LB_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && sample_tick && !lb_valid
    |=> lb_state_ff == LAOR_LB_IDLE)
    else $error("burnout active with zero interval");
  AST_LB_TYPE: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && sample_tick && alarm_one_source_type != `LAOR_ALM_TYPE_LB
    |=> lb_state_ff == LAOR_LB_IDLE)
    else $error("burnout with wrong alarm type");
  AST_LB_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && sample_tick && lb_state_ff == LAOR_LB_TRIP
    |=> loop_burnout_alarm_ff)
    else $error("burnout not flagged");
  AST_LB_LOCK: assert property (@(posedge pclk) disable iff (!presetn)
    !lb_valid && $stable(analog) |=> $stable(lblevel_ff))
    else $error("level changed while unavailable");
  AST_PEND_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && sample_tick && sel_ff[4:0] == LAOR_SRC_PEND && !pattern_on
    |=> !ctrl_out1_ff)
    else $error("program end routed with pattern off");
  AST_OUT2_COOL: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && heat_cool && !wr |=> sel_ff[9:5] == LAOR_SRC_COOL)
    else $error("output 2 not forced to cooling");
  AST_COOL_STD: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && sample_tick && sel_ff[9:5] == LAOR_SRC_COOL && !heat_cool
    |=> !ctrl_out2_ff)
    else $error("cooling drives output in standard control");
  AST_TICK_ONLY: assert property (@(posedge pclk) disable iff (!presetn)
    !(clk_en && sample_tick) |=> $stable(aux_out1_ff))
    else $error("output moved between ticks");
  CVR_TRIP: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(loop_burnout_alarm_ff));
  CVR_HS: cover property (@(posedge pclk) disable iff (!presetn)
    $fell(hs_alarm_ff));
  CVR_SEL: cover property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == `LAOR_OFF_SEL);
endmodule

// ### bench/laor_core_tb.sv
// self-checking bench for loop alarm and output routing
`include "laor_params.svh"
module laor_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import laor_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic sample_tick = 1'b0;
  logic clk_en = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er, o1, o2, a1, al1, lb;
  laor_sig_t sigs = '0;
  logic [15:0] hs_cur = 16'h0;
  logic [15:0] hs_lim = 16'h0;
  logic [15:0] dev = 16'h0;
  int bad_count = 0;
  int n_checks = 0;

  always #2.5 pclk = ~pclk;

  laor_core u_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .sample_tick(sample_tick), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sigs(sigs),
    .heater_short_current(hs_cur), .heater_short_limit(hs_lim),
    .deviation(dev), .ctrl_out1_ff(o1), .ctrl_out2_ff(o2),
    .aux_out1_ff(a1), .alarm_one_source_ff(al1),
    .loop_burnout_alarm_ff(lb));

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // an edge passes before setup so a release and a new request never collide
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 20) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
      results();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd, er);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, rd, er);
    chk(rd, exp);
  endtask

  // one-cycle tick, then two edges so the routed levels have landed
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge pclk);
      sample_tick <= 1'b1;
      @(posedge pclk);
      sample_tick <= 1'b0;
      repeat (2) @(posedge pclk);
    end
  endtask

  task automatic rst();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  function automatic logic route(input logic [4:0] c, input laor_sig_t s,
                                 input logic hc, input logic pat);
    case (c)
      5'h00: return 1'b0;
      5'h01: return s.heat;
      5'h02: return s.cool & hc;
      5'h03: return 1'b0;
      5'h04: return s.alm2;
      5'h05: return s.alm3;
      5'h06: return s.prog_end & pat;
      5'h07: return s.switch_count_alarm_source;
      default: return s.work_bits[c[2:0]];
    endcase
  endfunction

  initial begin
    logic [4:0] c;
    logic pat;
    int i;
    int k;
    i = $urandom(99508);
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rdc(`LAOR_OFF_SEL, 32'h0000_0c01);
    rdc(`LAOR_OFF_HYST, 32'h1);
    rdc(`LAOR_OFF_LBTIME, 32'h0);
    rdc(`LAOR_OFF_LBLEVEL, 32'h50);
    rdc(`LAOR_OFF_LBBAND, 32'h1e);
    apb(1'b0, 12'h020, 32'h0, rd, er);
    chk(er, 1'b1);
    // alarm one stays low here: heater-short unused, no burnout armed
    for (k = 0; k < 48; k++) begin
      c = 5'(k % 16);
      pat = 1'($urandom);
      wr(`LAOR_OFF_CTRL, 32'h0000_00c2 | (32'(pat) << 5));
      wr(`LAOR_OFF_SEL, {17'h0, c, c, c});
      rdc(`LAOR_OFF_SEL, {17'h0, c, c, c});
      sigs <= laor_sig_t'($urandom);
      tick(1);
      chk(o1, route(c, sigs, 1'b0, pat));
      chk(o2, route(c, sigs, 1'b0, pat));
      chk(a1, route(c, sigs, 1'b0, pat));
    end
    wr(`LAOR_OFF_SEL, 32'h0421);
    sigs <= laor_sig_t'(14'h2000);
    tick(1);
    chk(o1, 1'b1);
    sigs <= '0;
    repeat (6) @(posedge pclk);
    chk(o1, 1'b1);
    tick(1);
    chk(o1, 1'b0);
    // with the enable low a tick must not move routed output 1
    clk_en <= 1'b0;
    sigs <= laor_sig_t'(14'h2000);
    tick(1);
    chk(o1, 1'b0);
    clk_en <= 1'b1;
    sigs <= '0;
    wr(`LAOR_OFF_CTRL, 32'h0062);
    wr(`LAOR_OFF_SEL, 32'h0424);
    rdc(`LAOR_OFF_SEL, 32'h0421);
    wr(`LAOR_OFF_CTRL, 32'h00a2);
    wr(`LAOR_OFF_SEL, 32'h2108);
    rdc(`LAOR_OFF_SEL, 32'h0421);
    wr(`LAOR_OFF_CTRL, 32'h0162);
    wr(`LAOR_OFF_SEL, 32'h0422);
    rdc(`LAOR_OFF_SEL, 32'h0421);
    wr(`LAOR_OFF_CTRL, 32'h0362);
    wr(`LAOR_OFF_SEL, 32'h0422);
    rdc(`LAOR_OFF_SEL, 32'h0422);
    wr(`LAOR_OFF_CTRL, 32'h00ca);
    rdc(`LAOR_OFF_SEL, 32'h0442);
    sigs <= laor_sig_t'(14'h1000);
    tick(1);
    chk(o1, 1'b1);
    chk(o2, 1'b1);
    wr(`LAOR_OFF_CTRL, 32'h0010);
    rdc(`LAOR_OFF_LBLEVEL, 32'h3e8);
    rdc(`LAOR_OFF_LBBAND, 32'h14);
    wr(`LAOR_OFF_HYST, 32'h1f5);
    rdc(`LAOR_OFF_HYST, 32'h1f4);
    wr(`LAOR_OFF_HYST, 32'h0);
    rdc(`LAOR_OFF_HYST, 32'h1);
    wr(`LAOR_OFF_HYST, 32'h5);
    wr(`LAOR_OFF_CTRL, 32'h0003);
    hs_lim <= 16'd100;
    hs_cur <= 16'd100;
    tick(2);
    chk(al1, 1'b1);
    hs_cur <= 16'd97;
    tick(2);
    chk(al1, 1'b1);
    hs_cur <= 16'd94;
    tick(2);
    chk(al1, 1'b0);
    wr(`LAOR_OFF_CTRL, 32'h0007);
    hs_cur <= 16'd100;
    tick(2);
    hs_cur <= 16'd0;
    tick(2);
    chk(al1, 1'b1);
    // latched alarm would mask the burnout checks, so start clean
    rst();
    wr(`LAOR_OFF_CTRL, 32'hc002);
    dev <= 16'd200;
    tick(8);
    chk(lb, 1'b0);
    wr(`LAOR_OFF_LBLEVEL, 32'd50);
    rdc(`LAOR_OFF_LBLEVEL, 32'h50);
    wr(`LAOR_OFF_LBTIME, 32'h2710);
    rdc(`LAOR_OFF_LBTIME, 32'h270f);
    wr(`LAOR_OFF_LBTIME, 32'h1);
    wr(`LAOR_OFF_CTRL, 32'hb002);
    tick(10);
    chk(lb, 1'b0);
    wr(`LAOR_OFF_CTRL, 32'hc002);
    for (i = 0; i < 10; i++) begin
      dev <= 16'(1000 - 40 * i);
      tick(1);
    end
    chk(lb, 1'b0);
    dev <= 16'd200;
    for (i = 0; i < 16 && lb !== 1'b1; i++) tick(1);
    chk(lb, 1'b1);
    chk(al1, 1'b1);
    results();
  end
endmodule
